// file: dv/cto_host.sv
`timescale 1ns/1ps
module cto_host import cto_pkg::*; (
  input wire logic i_mclk,
  output logic [3:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  initial begin
    o_addr = 4'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end

  // one-cycle strobe; address and data held through the taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk) #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_mclk) #1;
    o_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk) #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_mclk) #1;
    o_rd = 1'b0;
  endtask

  // below two the timer would toggle on every tick
  task automatic set_preset(input logic [15:0] p);
    logic [15:0] v;
    v = (p < 16'h0002) ? 16'h0002 : p;
    wr(ADDR_PRESET_HIGH, v[15:8]);
    wr(ADDR_PRESET_LOW, v[7:0]);
  endtask
endmodule

// file: dv/tb_cto_top.sv
`timescale 1ns/1ps
module tb_cto_top;
  import cto_pkg::*;
  logic mclk, rst_b, rd, wr, ext, xtal, txa, rd_seen;
  logic [3:0] addr;
  logic [7:0] wdata, alt, rdata, outport, m, c, lat;
  logic [1:0] op01;
  logic irq_n;
  logic [8:0] exp_q[$];
  logic [31:0] lfsr_q;
  logic [15:0] p;
  int fails, check_count, cyc, t0, t1;

  cto_host u_cto_host (.i_mclk(mclk), .o_addr(addr), .o_rd(rd), .o_wr(wr), .o_wdata(wdata));
  cto_top u_cto_top (.i_mclk(mclk), .i_rst_b(rst_b), .i_ce(1'b1), .i_addr(addr), .i_rd(rd),
    .i_wr(wr), .i_wdata(wdata), .i_ext_count_in(ext), .i_crystal_clock_in(xtal),
    .i_tx_clk_a_tick(txa), .i_tx_clk_b_tick(1'b0), .i_status_other(8'h00), .i_alt_src(alt),
    .i_op01_alt_sel(op01), .o_rdata(rdata), .o_irq_out_n(irq_n), .o_outport(outport));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // c=0: command read, data not checked
  task automatic rdx(input logic [3:0] a, input logic [7:0] e, input logic c);
    exp_q.push_back({c, e});
    u_cto_host.rd(a);
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge mclk) #1 txa = 1'b1;
      @(posedge mclk) #1 txa = 1'b0;
    end
    repeat (4) @(posedge mclk);
    #2;
  endtask

  task automatic rise(output int t);
    int n;
    logic q;
    n = 0;
    q = outport[WAVE_PIN];
    while (n < 5000 && !(q === 1'b0 && outport[WAVE_PIN] === 1'b1)) begin
      q = outport[WAVE_PIN];
      @(posedge mclk) #2;
      n++;
    end
    // a wave that never rises is a failure, not a silent period
    if (!(q === 1'b0 && outport[WAVE_PIN] === 1'b1)) fails++;
    t = cyc;
  endtask

  task automatic conclude;
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // clocks, read scoreboard, watchdog
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // crystal and external pins share one deterministic 6-cycle rate
  initial begin
    xtal = 1'b0;
    ext = 1'b0;
    forever begin
      repeat (3) @(posedge mclk);
      #1 xtal = ~xtal;
      ext = xtal;
    end
  end

  always @(posedge mclk) cyc++;
  always @(posedge mclk) rd_seen <= rd;

  always @(negedge mclk) begin
    logic [8:0] e;
    if (rd_seen === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[8])
        cmp("o_rdata", {8'h00, e[7:0]}, {8'h00, rdata});
    end
  end

  initial begin
    repeat (60000) @(posedge mclk);
    fails++;
    conclude();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    txa = 1'b0;
    op01 = 2'b00;
    lfsr_q = 32'h8AFA;
    alt = 8'h00;
    repeat (10) @(posedge mclk);
    #1 rst_b = 1'b1;
    repeat (16) lfsr_q = lfsr_next(lfsr_q);
    m = lfsr_q[7:0];
    c = lfsr_q[15:8];
    alt = lfsr_q[31:24];
    lat = m & ~c;
    settle();
    cmp("outport", 16'h00FF, {8'h00, outport});
    rdx(4'h0, 8'h00, 1'b1);
    u_cto_host.wr(ADDR_START_SETBITS, m);
    settle();
    cmp("outport", {8'h00, ~m}, {8'h00, outport});
    u_cto_host.wr(ADDR_STOP_CLRBITS, c);
    settle();
    cmp("outport", {8'h00, ~lat}, {8'h00, outport});
    op01 = 2'b11;
    u_cto_host.wr(ADDR_OUTPORT_SEL, 8'hF1);
    settle();
    cmp("outport", {8'h00, alt[7:4], ~lat[3], alt[2:0]}, {8'h00, outport});
    u_cto_host.wr(ADDR_OUTPORT_SEL, 8'h04);
    u_cto_host.wr(ADDR_INTERRUPT, 8'h08);
    for (int k = 4; k < 8; k++) begin
      lfsr_q = lfsr_next(lfsr_q);
      p = 16'h0002 + 16'(lfsr_q[1:0]);
      u_cto_host.wr(ADDR_CLK_SEL, 8'(k << CS_LSB));
      u_cto_host.set_preset(p);
      rdx(ADDR_START_SETBITS, 8'h00, 1'b0);
      rise(t0);
      rise(t1);
      cmp("wave_period", 16'(2 * p * 6 * (k[0] ? 16 : 1)), 16'(t1 - t0));
    end
    u_cto_host.wr(ADDR_CLK_SEL, 8'h60);
    u_cto_host.set_preset(16'h0002);
    rdx(ADDR_START_SETBITS, 8'h00, 1'b0);
    rise(t0);
    rdx(ADDR_INTERRUPT, 8'h08, 1'b1);
    cmp("irq_n", 16'h0000, {15'h0, irq_n});
    rdx(ADDR_STOP_CLRBITS, 8'h00, 1'b0);
    rdx(ADDR_INTERRUPT, 8'h00, 1'b1);
    #2 cmp("irq_n", 16'h0001, {15'h0, irq_n});
    rise(t0);
    u_cto_host.set_preset(16'h0004);
    rise(t1);
    cmp("wave_period", 16'd36, 16'(t1 - t0));
    lfsr_q = lfsr_next(lfsr_q);
    p = 16'h0002 + 16'(lfsr_q[2:0]);
    u_cto_host.wr(ADDR_CLK_SEL, 8'h10);
    // clear ready left by the timer runs so terminal count must set it
    rdx(ADDR_STOP_CLRBITS, 8'h00, 1'b0);
    rdx(ADDR_INTERRUPT, 8'h00, 1'b1);
    u_cto_host.set_preset(p);
    rdx(ADDR_START_SETBITS, 8'h00, 1'b0);
    tick(int'(p) - 1);
    cmp("irq_n", 16'h0001, {15'h0, irq_n});
    cmp("wave", 16'h0001, {15'h0, outport[WAVE_PIN]});
    tick(1);
    cmp("wave", 16'h0000, {15'h0, outport[WAVE_PIN]});
    cmp("irq_n", 16'h0000, {15'h0, irq_n});
    rdx(ADDR_INTERRUPT, 8'h08, 1'b1);
    tick(2);
    rdx(ADDR_STOP_CLRBITS, 8'h00, 1'b0);
    rdx(ADDR_PRESET_HIGH, 8'hFF, 1'b1);
    rdx(ADDR_PRESET_LOW, 8'hFE, 1'b1);
    rdx(ADDR_INTERRUPT, 8'h00, 1'b1);
    cmp("wave", 16'h0001, {15'h0, outport[WAVE_PIN]});
    u_cto_host.set_preset(p + 16'h0003);
    rdx(ADDR_PRESET_LOW, 8'hFE, 1'b1);
    rdx(ADDR_START_SETBITS, 8'h00, 1'b0);
    tick(int'(p) + 2);
    cmp("wave", 16'h0001, {15'h0, outport[WAVE_PIN]});
    tick(1);
    cmp("wave", 16'h0000, {15'h0, outport[WAVE_PIN]});
    settle();
    conclude();
  end
endmodule

// file: rtl/cto_pkg.sv
package cto_pkg;
  // ----------------------------------------
  // register addresses (A3-A0)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CLK_SEL = 4'h4;
  localparam logic [3:0] ADDR_INTERRUPT = 4'h5;
  localparam logic [3:0] ADDR_PRESET_HIGH = 4'h6;
  localparam logic [3:0] ADDR_PRESET_LOW = 4'h7;
  localparam logic [3:0] ADDR_OUTPORT_SEL = 4'hD;
  localparam logic [3:0] ADDR_START_SETBITS = 4'hE;
  localparam logic [3:0] ADDR_STOP_CLRBITS = 4'hF;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CS_LSB = 4;
  localparam int CS_MODE_BIT = 6;
  localparam int STATUS_READY_BIT = 3;
  localparam int SEL_OP2_LSB = 0;
  localparam int SEL_WAVE_LSB = 2;
  localparam int WAVE_PIN = 3;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CLK_SEL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] OUTPORT_SEL_RST = 8'h00;
  localparam logic [7:0] OUTPORT_LATCH_RST = 8'h00;
  localparam logic [15:0] PRESET_RST = 16'h0002;

  // ----------------------------------------
  // clock source field encodings
  // ----------------------------------------
  localparam logic [2:0] CS_CTR_EXT = 3'h0;
  localparam logic [2:0] CS_CTR_TXA = 3'h1;
  localparam logic [2:0] CS_CTR_TXB = 3'h2;
  localparam logic [2:0] CS_CTR_XTAL16 = 3'h3;
  localparam logic [2:0] CS_TMR_EXT = 3'h4;
  localparam logic [2:0] CS_TMR_EXT16 = 3'h5;
  localparam logic [2:0] CS_TMR_XTAL = 3'h6;
  localparam logic [2:0] CS_TMR_XTAL16 = 3'h7;

  localparam logic [1:0] WAVE_SRC_LATCH = 2'h0;
  localparam logic [1:0] WAVE_SRC_CT = 2'h1;

  localparam int PRESC_W = 4;
  localparam int SYNC_STAGES = 3;

  typedef enum logic [0:0] {CT_IDLE, CT_RUN} cto_ct_state_t;
endpackage

// file: rtl/cto_presc.sv
`timescale 1ns/1ps
module cto_presc import cto_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [2:0] i_cs,
  input wire logic i_ext_rise,
  input wire logic i_xtal_rise,
  input wire logic i_txa_tick,
  input wire logic i_txb_tick,
  output logic o_tick
);
  typedef struct packed {
    logic [PRESC_W-1:0] ext_div;
    logic [PRESC_W-1:0] xtal_div;
    logic tick;
  } cto_presc_st_t;

  cto_presc_st_t q, d;
  logic ext16, xtal16;

  // /16 with a 16-bit preset of 65535 gives a 1,048,560 divisor
  always_comb begin
    d = q;
    ext16 = i_ext_rise && (q.ext_div == '1);
    xtal16 = i_xtal_rise && (q.xtal_div == '1);
    if (i_ext_rise) begin
      d.ext_div = q.ext_div + 1'b1;
    end
    if (i_xtal_rise) begin
      d.xtal_div = q.xtal_div + 1'b1;
    end
    case (i_cs)
      CS_CTR_EXT, CS_TMR_EXT: d.tick = i_ext_rise;
      CS_TMR_EXT16: d.tick = ext16;
      CS_CTR_TXA: d.tick = i_txa_tick;
      CS_CTR_TXB: d.tick = i_txb_tick;
      CS_TMR_XTAL: d.tick = i_xtal_rise;
      CS_CTR_XTAL16, CS_TMR_XTAL16: d.tick = xtal16;
      default: d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_tick = q.tick;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  a_div16_tick: assert property (
    i_ce && i_cs == CS_TMR_XTAL16 && xtal16 |=> o_tick
  ) else $error("divided clock tick missing");
endmodule

// file: rtl/cto_sync.sv
`timescale 1ns/1ps
module cto_sync import cto_pkg::*; #(
  parameter int W = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_rise
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0] rise;
  } cto_sync_st_t;

  cto_sync_st_t q, d;

  // level moves only when stages two and three agree; s1 feeds s2 only
  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
    d.rise = d.lvl & ~q.lvl;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rise = q.rise;
endmodule

// file: rtl/cto_top.sv
`timescale 1ns/1ps
module cto_top import cto_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [3:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_ext_count_in,
  input wire logic i_crystal_clock_in,
  input wire logic i_tx_clk_a_tick,
  input wire logic i_tx_clk_b_tick,
  input wire logic [7:0] i_status_other,
  input wire logic [7:0] i_alt_src,
  input wire logic [1:0] i_op01_alt_sel,
  output logic [7:0] o_rdata,
  output logic o_irq_out_n,
  output logic [7:0] o_outport
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] clk_sel;
    logic [7:0] interrupt_mask;
    logic [7:0] outport_source_select;
    logic [7:0] outport_latch;
    logic [7:0] ct_preset_high;
    logic [7:0] ct_preset_low;
    logic [15:0] cnt;
    cto_ct_state_t st;
    logic wave;
    logic ready;
    logic [7:0] rdata;
    logic irq_n;
    logic [7:0] pins;
  } cto_st_t;

  localparam cto_st_t ST_RST = '{
    clk_sel: CLK_SEL_RST,
    interrupt_mask: MASK_RST,
    outport_source_select: OUTPORT_SEL_RST,
    outport_latch: OUTPORT_LATCH_RST,
    ct_preset_high: PRESET_RST[15:8],
    ct_preset_low: PRESET_RST[7:0],
    cnt: PRESET_RST,
    st: CT_IDLE,
    wave: 1'b1,
    ready: 1'b0,
    rdata: 8'h00,
    irq_n: 1'b1,
    pins: ~OUTPORT_LATCH_RST
  };

  cto_st_t q, d;
  logic tick, timer_mode, start, stop, set_rdy, wr_set, wr_clr;
  logic [15:0] preset;
  logic [7:0] status_d;
  logic [1:0] ext_rise;

  function automatic logic pin_pick(input logic alt_on, input logic alt, input logic latch);
    // latch drives the pin inverted
    pin_pick = alt_on ? alt : ~latch;
  endfunction

  // ----------------------------------------
  // pin sampling and clock source
  // ----------------------------------------
  cto_sync #(.W(2)) u_sync (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_async({i_crystal_clock_in, i_ext_count_in}),
    .o_rise(ext_rise)
  );

  // crystal and ext inputs must be well below a quarter of i_mclk
  cto_presc u_presc (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_cs(q.clk_sel[CS_LSB+2:CS_LSB]),
    .i_ext_rise(ext_rise[0]),
    .i_xtal_rise(ext_rise[1]),
    .i_txa_tick(i_tx_clk_a_tick),
    .i_txb_tick(i_tx_clk_b_tick),
    .o_tick(tick)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    preset = {q.ct_preset_high, q.ct_preset_low};
    timer_mode = q.clk_sel[CS_MODE_BIT];
    start = i_ce && i_rd && (i_addr == ADDR_START_SETBITS);
    stop = i_ce && i_rd && (i_addr == ADDR_STOP_CLRBITS);
    wr_set = i_ce && i_wr && (i_addr == ADDR_START_SETBITS);
    wr_clr = i_ce && i_wr && (i_addr == ADDR_STOP_CLRBITS);
    set_rdy = 1'b0;

    if (i_ce && i_wr) begin
      case (i_addr)
        ADDR_CLK_SEL: d.clk_sel = i_wdata;
        ADDR_INTERRUPT: d.interrupt_mask = i_wdata;
        ADDR_PRESET_HIGH: d.ct_preset_high = i_wdata;
        ADDR_PRESET_LOW: d.ct_preset_low = i_wdata;
        ADDR_OUTPORT_SEL: d.outport_source_select = i_wdata;
        default: d.clk_sel = q.clk_sel;
      endcase
    end
    if (wr_set) begin
      d.outport_latch = q.outport_latch | i_wdata;
    end
    if (wr_clr) begin
      d.outport_latch = q.outport_latch & ~i_wdata;
    end

    // count engine; the count is only loaded at start or a timer reload
    if (q.st == CT_RUN && tick && i_ce) begin
      if (timer_mode) begin
        if (q.cnt <= 16'h0001) begin
          d.cnt = preset;
          d.wave = ~q.wave;
          set_rdy = q.wave;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end else begin
        d.cnt = q.cnt - 16'h0001;
        if (q.cnt == 16'h0001) begin
          set_rdy = 1'b1;
          d.wave = 1'b0;
        end
      end
    end
    if (start) begin
      d.st = CT_RUN;
      d.cnt = preset;
      d.wave = 1'b1;
    end
    if (stop && !timer_mode) begin
      d.st = CT_IDLE;
      d.wave = 1'b1;
    end
    // a terminal count in the stop cycle is kept
    if (set_rdy) begin
      d.ready = 1'b1;
    end else if (stop) begin
      d.ready = 1'b0;
    end

    status_d = i_status_other;
    status_d[STATUS_READY_BIT] = d.ready;
    d.irq_n = ~|(status_d & d.interrupt_mask);

    if (i_ce && i_rd) begin
      case (i_addr)
        ADDR_INTERRUPT: d.rdata = status_d;
        ADDR_PRESET_HIGH: d.rdata = q.cnt[15:8];
        ADDR_PRESET_LOW: d.rdata = q.cnt[7:0];
        default: d.rdata = 8'h00;
      endcase
    end

    // output pins
    for (int i = 0; i < 2; i++) begin
      d.pins[i] = pin_pick(i_op01_alt_sel[i], i_alt_src[i], d.outport_latch[i]);
    end
    d.pins[2] = pin_pick(d.outport_source_select[SEL_OP2_LSB+:2] != 2'h0, i_alt_src[2],
                         d.outport_latch[2]);
    case (d.outport_source_select[SEL_WAVE_LSB+:2])
      WAVE_SRC_LATCH: d.pins[WAVE_PIN] = ~d.outport_latch[WAVE_PIN];
      WAVE_SRC_CT: d.pins[WAVE_PIN] = d.wave;
      default: d.pins[WAVE_PIN] = i_alt_src[WAVE_PIN];
    endcase
    for (int i = 4; i < 8; i++) begin
      d.pins[i] = pin_pick(d.outport_source_select[i], i_alt_src[i], d.outport_latch[i]);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      q <= ST_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_rdata = q.rdata;
  assign o_irq_out_n = q.irq_n;
  assign o_outport = q.pins;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  sequence s_timer_end;
    q.st == CT_RUN && timer_mode && tick && i_ce && q.cnt == 16'h0001;
  endsequence

  sequence s_ctr_end;
    q.st == CT_RUN && !timer_mode && tick && i_ce && !start && !stop;
  endsequence

  sequence s_preset_wr;
    i_ce && i_wr && (i_addr == ADDR_PRESET_HIGH || i_addr == ADDR_PRESET_LOW);
  endsequence

  a_start_load: assert property (
    start |=> q.st == CT_RUN && q.cnt == $past(preset)
  ) else $error("start did not load preset");

  a_idle_hold: assert property (
    q.st == CT_IDLE && !start |=> $stable(q.cnt)
  ) else $error("idle counter moved");

  a_half_reload: assert property (
    s_timer_end ##0 !start |=> q.cnt == $past(preset) && q.wave != $past(q.wave)
  ) else $error("timer half period reload wrong");

  a_timer_ready: assert property (
    s_timer_end ##0 (q.wave && !start) |=> q.ready
  ) else $error("timer ready not set");

  // stop in timer mode only clears ready; the run state must survive it
  a_timer_stop: assert property (
    stop && timer_mode && !set_rdy |=> !q.ready && q.st == $past(q.st)
  ) else $error("timer stop wrong");

  a_ctr_terminal: assert property (
    s_ctr_end ##0 q.cnt == 16'h0001 |=> q.ready && !q.wave && q.cnt == 16'h0000
  ) else $error("terminal count not flagged");

  a_ctr_step: assert property (
    s_ctr_end |=> q.cnt == $past(q.cnt) - 16'h0001
  ) else $error("counter did not decrement");

  a_ctr_wrap: assert property (
    s_ctr_end ##0 q.cnt == 16'h0000 |=> q.cnt == 16'hFFFF && q.st == CT_RUN
  ) else $error("counter did not wrap");

  a_ctr_stop: assert property (
    stop && !timer_mode && !set_rdy |=> q.st == CT_IDLE && q.wave && !q.ready
  ) else $error("stop did not halt counter");

  a_irq_gate: assert property (
    q.ready && q.interrupt_mask[STATUS_READY_BIT] |-> !o_irq_out_n
  ) else $error("interrupt not asserted");

  a_set_bits: assert property (
    wr_set |=> q.outport_latch == ($past(q.outport_latch) | $past(i_wdata))
  ) else $error("set bits wrong");

  a_latch_inv: assert property (
    !q.outport_source_select[4] |-> o_outport[4] == ~q.outport_latch[4]
  ) else $error("latch pin not inverted");

  a_preset_hidden: assert property (
    i_ce && i_rd && i_addr == ADDR_PRESET_LOW |=> o_rdata == $past(q.cnt[7:0])
  ) else $error("count readback wrong");

  a_status_read: assert property (
    i_ce && i_rd && i_addr == ADDR_INTERRUPT |=> o_rdata[STATUS_READY_BIT] == q.ready
  ) else $error("status read lost ready");

  a_clr_bits: assert property (
    wr_clr |=> q.outport_latch == ($past(q.outport_latch) & ~$past(i_wdata))
  ) else $error("clear bits wrong");

  // preset writes never touch the running count, only later loads
  a_preset_defer: assert property (
    s_preset_wr ##0 (!start && !(q.st == CT_RUN && tick)) |=> $stable(q.cnt)
  ) else $error("preset write moved the count");

  a_idle_wave: assert property (
    q.st == CT_IDLE |-> q.wave
  ) else $error("idle counter output not high");
endmodule
